// ==== design/sdcr_pkg.sv ====
// package of constants and types for the sound demodulator configuration registers
package sdcr_pkg;

    // ------------------------------------------------------------
    // subaddress map
    // ------------------------------------------------------------
    localparam logic [7:0] SDCR_SUB_MON_SELECT = 8'h02;
    localparam logic [7:0] SDCR_SUB_C1_HIGH = 8'h03;
    localparam logic [7:0] SDCR_SUB_C1_MID = 8'h04;
    localparam logic [7:0] SDCR_SUB_C1_LOW = 8'h05;
    localparam logic [7:0] SDCR_SUB_C2_HIGH = 8'h06;
    localparam logic [7:0] SDCR_SUB_C2_MID = 8'h07;
    localparam logic [7:0] SDCR_SUB_C2_LOW = 8'h08;
    localparam logic [7:0] SDCR_SUB_DEMOD_CFG = 8'h09;
    localparam logic [7:0] SDCR_SUB_STEP = 8'h01;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SDCR_BYTE_RESET = 8'h00;
    localparam logic [23:0] SDCR_WORD_RESET = 24'h000000;
    localparam logic [7:0] SDCR_MON_RESET = 8'h00;
    localparam logic [7:0] SDCR_CFG_RESET = 8'h00;

    // ------------------------------------------------------------
    // monitor select byte fields
    // ------------------------------------------------------------
    localparam int SDCR_MON_CHAN_HI = 4;
    localparam int SDCR_MON_CHAN_LO = 3;
    localparam int SDCR_MON_SRC_HI = 1;
    localparam int SDCR_MON_SRC_LO = 0;
    // writable bits of the monitor select byte; the rest stay zero
    localparam logic [7:0] SDCR_MON_MASK = 8'h1B;

    localparam logic [1:0] SDCR_MCH_AVERAGE = 2'h0;
    localparam logic [1:0] SDCR_MCH_ONE = 2'h1;
    localparam logic [1:0] SDCR_MCH_TWO = 2'h2;

    localparam logic [1:0] SDCR_MSRC_DC = 2'h0;
    localparam logic [1:0] SDCR_MSRC_MAGPHASE = 2'h1;
    localparam logic [1:0] SDCR_MSRC_FMAM = 2'h2;
    localparam logic [1:0] SDCR_MSRC_NICAM = 2'h3;

    // ------------------------------------------------------------
    // demodulator configuration byte fields
    // ------------------------------------------------------------
    localparam int SDCR_CFG_IDENT_HI = 7;
    localparam int SDCR_CFG_IDENT_LO = 6;
    localparam int SDCR_CFG_REGION = 5;
    localparam int SDCR_CFG_FILT_HI = 4;
    localparam int SDCR_CFG_CH2_HI = 3;
    localparam int SDCR_CFG_CH2_LO = 2;
    localparam int SDCR_CFG_FILT_LO = 1;
    localparam int SDCR_CFG_CH1_AM = 0;

    localparam logic [1:0] SDCR_ID_SLOW = 2'h0;
    localparam logic [1:0] SDCR_ID_MEDIUM = 2'h1;
    localparam logic [1:0] SDCR_ID_FAST = 2'h2;
    localparam logic [1:0] SDCR_ID_OFF = 2'h3;

    localparam logic [1:0] SDCR_CH2_FM = 2'h0;
    localparam logic [1:0] SDCR_CH2_AM = 2'h1;
    localparam logic [1:0] SDCR_CH2_NICAM = 2'h2;

    localparam logic [1:0] SDCR_FBW_NARROW = 2'h0;
    localparam logic [1:0] SDCR_FBW_EXTRA = 2'h1;
    localparam logic [1:0] SDCR_FBW_MEDIUM = 2'h2;
    localparam logic [1:0] SDCR_FBW_WIDE = 2'h3;

    // per-channel bandwidth reported to the datapath
    typedef enum logic [1:0] {
        SDCR_BW_NARROW,
        SDCR_BW_MEDIUM,
        SDCR_BW_WIDE,
        SDCR_BW_EXTRA_WIDE
    } sdcr_bw_type;

    // ------------------------------------------------------------
    // host-side word computation reference
    // ------------------------------------------------------------
    localparam int SDCR_MIXER_CLOCK_FREQ_KHZ = 12288;
    localparam int SDCR_WORD_STEPS_LOG2 = 24;

    // ------------------------------------------------------------
    // identification timing
    // ------------------------------------------------------------
    localparam logic [31:0] SDCR_ID_CNT_ZERO = 32'h00000000;
    localparam logic [31:0] SDCR_ID_CNT_STEP = 32'h00000001;

    // whole state of the register bank
    typedef struct packed {
        logic busy;
        logic [7:0] sub;
        logic [7:0] c1_high;
        logic [7:0] c1_mid;
        logic c1_high_ok;
        logic c1_mid_ok;
        logic [7:0] c2_high;
        logic [7:0] c2_mid;
        logic c2_high_ok;
        logic c2_mid_ok;
        logic [23:0] c1_word;
        logic [23:0] c2_word;
        logic c1_load;
        logic c2_load;
        logic [7:0] mon;
        logic [7:0] cfg;
        logic [31:0] id_cnt;
        logic id_due;
    } sdcr_state_type;

endpackage

// ==== design/sdcr_regs.sv ====
// write-side configuration register bank of the sound demodulator
//
// Contract
// - monitor channel: average, channel one, channel two
// - monitor source: DC, magnitude/phase, FM/AM, NICAM
// - carrier one word from subaddresses 3..5
// - carrier word applied only when fully received
// - cut-short transfer discards partial carrier bytes
// - carrier one word resets to zero
// - carrier two word at subaddresses 6..8
// - carrier two tunes second FM or NICAM
// - demodulator config at subaddress 9, reset zero
// - filter code from config bits 4 and 1
// - ident time slow/medium/fast, 11 off and reset
// - ident result due within twice integrator time
// - region bit selects Korean or European pilots
// - channel two FM/AM/NICAM, NICAM wider decimation
// - channel one AM when bit 0 set
// - filter codes map to channel bandwidths
// - monitor fields in bits 4:3 and 1:0
`timescale 1ns/1ns
module sdcr_regs
    import sdcr_pkg::*;
#(
    parameter logic [31:0] IDENT_SLOW_CYCLES = 32'h00100000,
    parameter logic [31:0] IDENT_MEDIUM_CYCLES = 32'h00040000,
    parameter logic [31:0] IDENT_FAST_CYCLES = 32'h00010000
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic XFER_START_IN,
    input wire logic [7:0] XFER_SUBADDR_IN,
    input wire logic BYTE_STROBE_IN,
    input wire logic [7:0] BYTE_DATA_IN,
    input wire logic XFER_END_IN,
    output logic [23:0] CARRIER_ONE_WORD_OUT,
    output logic CARRIER_ONE_LOAD_OUT,
    output logic [23:0] CARRIER_TWO_WORD_OUT,
    output logic CARRIER_TWO_LOAD_OUT,
    output logic CARRIER_TWO_NICAM_OUT,
    output logic MON_CHAN_AVG_OUT,
    output logic MON_CHAN_ONE_OUT,
    output logic MON_CHAN_TWO_OUT,
    output logic [3:0] MON_SRC_SEL_OUT,
    output logic [7:0] MON_SELECT_OUT,
    output logic [7:0] DEMOD_CONFIG_OUT,
    output logic [1:0] IDENT_TIME_OUT,
    output logic IDENT_RESET_OUT,
    output logic IDENT_REGION_KOREA_OUT,
    output logic IDENT_RESULT_DUE_OUT,
    output logic [1:0] FILT_WIDTH_OUT,
    output sdcr_bw_type CH1_BW_OUT,
    output sdcr_bw_type CH2_BW_OUT,
    output logic CH1_FM_ALLOWED_OUT,
    output logic CH2_FM_ALLOWED_OUT,
    output logic CHAN_ONE_AM_OUT,
    output logic [1:0] CHAN_TWO_MODE_OUT,
    output logic CH2_WIDE_DECIM_OUT
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sdcr_state_type st_r;
    sdcr_state_type st_nxt;
    logic [31:0] id_limit;
    logic [1:0] mon_chan;
    logic [1:0] mon_src;
    logic [1:0] id_mode;
    logic [1:0] ch2_mode;
    logic [1:0] filt_code;

    assign mon_chan = {st_r.mon[SDCR_MON_CHAN_HI], st_r.mon[SDCR_MON_CHAN_LO]};
    assign mon_src = {st_r.mon[SDCR_MON_SRC_HI], st_r.mon[SDCR_MON_SRC_LO]};
    assign id_mode = {st_r.cfg[SDCR_CFG_IDENT_HI], st_r.cfg[SDCR_CFG_IDENT_LO]};
    assign ch2_mode = {st_r.cfg[SDCR_CFG_CH2_HI], st_r.cfg[SDCR_CFG_CH2_LO]};
    assign filt_code = {st_r.cfg[SDCR_CFG_FILT_HI], st_r.cfg[SDCR_CFG_FILT_LO]};

    // twice the integrator time bounds the wait for a valid result
    always_comb begin
        unique case (id_mode)
            SDCR_ID_SLOW: id_limit = IDENT_SLOW_CYCLES + IDENT_SLOW_CYCLES;
            SDCR_ID_MEDIUM: id_limit = IDENT_MEDIUM_CYCLES + IDENT_MEDIUM_CYCLES;
            SDCR_ID_FAST: id_limit = IDENT_FAST_CYCLES + IDENT_FAST_CYCLES;
            SDCR_ID_OFF: id_limit = SDCR_ID_CNT_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic cfg_written;
        cfg_written = 1'b0;
        st_nxt = st_r;
        st_nxt.c1_load = 1'b0;
        st_nxt.c2_load = 1'b0;
        if (XFER_START_IN) begin
            // a new transfer begins with nothing collected
            st_nxt.busy = 1'b1;
            st_nxt.sub = XFER_SUBADDR_IN;
            st_nxt.c1_high_ok = 1'b0;
            st_nxt.c1_mid_ok = 1'b0;
            st_nxt.c2_high_ok = 1'b0;
            st_nxt.c2_mid_ok = 1'b0;
        end else if (BYTE_STROBE_IN && st_r.busy) begin
            st_nxt.sub = st_r.sub + SDCR_SUB_STEP;
            unique case (st_r.sub)
                SDCR_SUB_MON_SELECT: begin
                    st_nxt.mon = BYTE_DATA_IN & SDCR_MON_MASK;
                end
                SDCR_SUB_C1_HIGH: begin
                    st_nxt.c1_high = BYTE_DATA_IN;
                    st_nxt.c1_high_ok = 1'b1;
                    st_nxt.c1_mid_ok = 1'b0;
                end
                SDCR_SUB_C1_MID: begin
                    st_nxt.c1_mid = BYTE_DATA_IN;
                    st_nxt.c1_mid_ok = st_r.c1_high_ok;
                end
                SDCR_SUB_C1_LOW: begin
                    if (st_r.c1_high_ok && st_r.c1_mid_ok) begin
                        st_nxt.c1_word = {st_r.c1_high, st_r.c1_mid, BYTE_DATA_IN};
                        st_nxt.c1_load = 1'b1;
                    end
                    st_nxt.c1_high_ok = 1'b0;
                    st_nxt.c1_mid_ok = 1'b0;
                end
                SDCR_SUB_C2_HIGH: begin
                    st_nxt.c2_high = BYTE_DATA_IN;
                    st_nxt.c2_high_ok = 1'b1;
                    st_nxt.c2_mid_ok = 1'b0;
                end
                SDCR_SUB_C2_MID: begin
                    st_nxt.c2_mid = BYTE_DATA_IN;
                    st_nxt.c2_mid_ok = st_r.c2_high_ok;
                end
                SDCR_SUB_C2_LOW: begin
                    if (st_r.c2_high_ok && st_r.c2_mid_ok) begin
                        st_nxt.c2_word = {st_r.c2_high, st_r.c2_mid, BYTE_DATA_IN};
                        st_nxt.c2_load = 1'b1;
                    end
                    st_nxt.c2_high_ok = 1'b0;
                    st_nxt.c2_mid_ok = 1'b0;
                end
                SDCR_SUB_DEMOD_CFG: begin
                    st_nxt.cfg = BYTE_DATA_IN;
                    cfg_written = 1'b1;
                end
                default: begin
                    // bytes outside this bank belong to other blocks
                end
            endcase
        end
        if (XFER_END_IN && !XFER_START_IN) begin
            // stop, early or not, drops any half-built word
            st_nxt.busy = 1'b0;
            st_nxt.c1_high_ok = 1'b0;
            st_nxt.c1_mid_ok = 1'b0;
            st_nxt.c2_high_ok = 1'b0;
            st_nxt.c2_mid_ok = 1'b0;
        end
        // any config write restarts identification; off holds it in reset
        if (cfg_written || id_mode == SDCR_ID_OFF) begin
            st_nxt.id_cnt = SDCR_ID_CNT_ZERO;
            st_nxt.id_due = 1'b0;
        end else if (!st_r.id_due) begin
            st_nxt.id_cnt = st_r.id_cnt + SDCR_ID_CNT_STEP;
            if (st_nxt.id_cnt >= id_limit) begin
                st_nxt.id_due = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            st_r.busy <= 1'b0;
            st_r.sub <= SDCR_BYTE_RESET;
            st_r.c1_high <= SDCR_BYTE_RESET;
            st_r.c1_mid <= SDCR_BYTE_RESET;
            st_r.c1_high_ok <= 1'b0;
            st_r.c1_mid_ok <= 1'b0;
            st_r.c2_high <= SDCR_BYTE_RESET;
            st_r.c2_mid <= SDCR_BYTE_RESET;
            st_r.c2_high_ok <= 1'b0;
            st_r.c2_mid_ok <= 1'b0;
            st_r.c1_word <= SDCR_WORD_RESET;
            st_r.c2_word <= SDCR_WORD_RESET;
            st_r.c1_load <= 1'b0;
            st_r.c2_load <= 1'b0;
            st_r.mon <= SDCR_MON_RESET;
            st_r.cfg <= SDCR_CFG_RESET;
            st_r.id_cnt <= SDCR_ID_CNT_ZERO;
            st_r.id_due <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // decoded settings for the datapath
    // ------------------------------------------------------------
    assign CARRIER_ONE_WORD_OUT = st_r.c1_word;
    assign CARRIER_ONE_LOAD_OUT = st_r.c1_load;
    assign CARRIER_TWO_WORD_OUT = st_r.c2_word;
    assign CARRIER_TWO_LOAD_OUT = st_r.c2_load;
    assign CARRIER_TWO_NICAM_OUT = (ch2_mode == SDCR_CH2_NICAM);
    assign MON_SELECT_OUT = st_r.mon;
    assign DEMOD_CONFIG_OUT = st_r.cfg;

    // reserved channel code 11 selects nothing
    assign MON_CHAN_AVG_OUT = (mon_chan == SDCR_MCH_AVERAGE);
    assign MON_CHAN_ONE_OUT = (mon_chan == SDCR_MCH_ONE);
    assign MON_CHAN_TWO_OUT = (mon_chan == SDCR_MCH_TWO);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_src
            assign MON_SRC_SEL_OUT[gi] = (mon_src == 2'(gi));
        end
    endgenerate

    assign IDENT_TIME_OUT = id_mode;
    assign IDENT_RESET_OUT = (id_mode == SDCR_ID_OFF);
    assign IDENT_REGION_KOREA_OUT = st_r.cfg[SDCR_CFG_REGION];
    assign IDENT_RESULT_DUE_OUT = st_r.id_due;
    assign FILT_WIDTH_OUT = filt_code;
    assign CHAN_ONE_AM_OUT = st_r.cfg[SDCR_CFG_CH1_AM];
    assign CHAN_TWO_MODE_OUT = ch2_mode;
    assign CH2_WIDE_DECIM_OUT = (ch2_mode == SDCR_CH2_NICAM);
    assign CH1_FM_ALLOWED_OUT = ~st_r.cfg[SDCR_CFG_CH1_AM];

    always_comb begin
        unique case (filt_code)
            SDCR_FBW_NARROW: begin
                CH1_BW_OUT = SDCR_BW_NARROW;
                CH2_BW_OUT = SDCR_BW_NARROW;
                CH2_FM_ALLOWED_OUT = 1'b1;
            end
            SDCR_FBW_EXTRA: begin
                CH1_BW_OUT = SDCR_BW_EXTRA_WIDE;
                CH2_BW_OUT = SDCR_BW_NARROW;
                // only channel one may demodulate FM here; NICAM still runs on two
                CH2_FM_ALLOWED_OUT = 1'b0;
            end
            SDCR_FBW_MEDIUM: begin
                CH1_BW_OUT = SDCR_BW_MEDIUM;
                CH2_BW_OUT = SDCR_BW_MEDIUM;
                CH2_FM_ALLOWED_OUT = 1'b1;
            end
            SDCR_FBW_WIDE: begin
                CH1_BW_OUT = SDCR_BW_WIDE;
                CH2_BW_OUT = SDCR_BW_WIDE;
                CH2_FM_ALLOWED_OUT = 1'b1;
            end
        endcase
    end

endmodule

// ==== dv/sdcr_regs_properties.sv ====
// concurrent checks on the ports of the configuration register bank
`timescale 1ns/1ns
module sdcr_regs_checker
    import sdcr_pkg::*;
(
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic BYTE_STROBE_IN,
    input wire logic [7:0] BYTE_DATA_IN,
    input wire logic [23:0] CARRIER_ONE_WORD_OUT,
    input wire logic CARRIER_ONE_LOAD_OUT,
    input wire logic [23:0] CARRIER_TWO_WORD_OUT,
    input wire logic CARRIER_TWO_LOAD_OUT,
    input wire logic MON_CHAN_AVG_OUT,
    input wire logic MON_CHAN_ONE_OUT,
    input wire logic MON_CHAN_TWO_OUT,
    input wire logic [3:0] MON_SRC_SEL_OUT,
    input wire logic [7:0] MON_SELECT_OUT,
    input wire logic [7:0] DEMOD_CONFIG_OUT,
    input wire logic IDENT_RESET_OUT,
    input wire logic IDENT_RESULT_DUE_OUT,
    input wire logic [1:0] FILT_WIDTH_OUT,
    input wire sdcr_bw_type CH1_BW_OUT,
    input wire sdcr_bw_type CH2_BW_OUT,
    input wire logic CH2_FM_ALLOWED_OUT,
    input wire logic CH2_WIDE_DECIM_OUT
);
default clocking cb @(posedge CLK_SYS_IN); endclocking
default disable iff (!RST_N_IN);
// a commit is a single-cycle pulse that follows the low byte
sequence pulse_seq(logic ld);
    ld ##1 !ld;
endsequence
AST_C1_PULSE: assert property (CARRIER_ONE_LOAD_OUT |-> pulse_seq(CARRIER_ONE_LOAD_OUT) and $past(BYTE_STROBE_IN)
    && CARRIER_ONE_WORD_OUT[7:0] == $past(BYTE_DATA_IN)) else $error("carrier one commit not tied to low byte");
AST_C1_HOLD: assert property (!CARRIER_ONE_LOAD_OUT |-> $stable(CARRIER_ONE_WORD_OUT))
    else $error("carrier one word changed without commit");
AST_C2_HOLD: assert property (!CARRIER_TWO_LOAD_OUT |-> $stable(CARRIER_TWO_WORD_OUT))
    else $error("carrier two word changed without commit");
AST_MON_CHAN: assert property ({MON_CHAN_AVG_OUT, MON_CHAN_ONE_OUT, MON_CHAN_TWO_OUT} ==
    {MON_SELECT_OUT[4:3] == SDCR_MCH_AVERAGE, MON_SELECT_OUT[4:3] == SDCR_MCH_ONE, MON_SELECT_OUT[4:3] == SDCR_MCH_TWO})
    else $error("monitor channel decode wrong");
AST_MON_SRC: assert property (MON_SRC_SEL_OUT == 4'(4'h1 << MON_SELECT_OUT[1:0]))
    else $error("monitor source decode wrong");
AST_MON_MASK: assert property ((MON_SELECT_OUT & ~SDCR_MON_MASK) == 8'h00)
    else $error("monitor byte holds unused bits");
AST_FILT: assert property (FILT_WIDTH_OUT == {DEMOD_CONFIG_OUT[4], DEMOD_CONFIG_OUT[1]})
    else $error("filter code not from bits 4 and 1");
AST_IDENT_OFF: assert property (IDENT_RESET_OUT == (DEMOD_CONFIG_OUT[7:6] == SDCR_ID_OFF)
    && (IDENT_RESET_OUT -> !IDENT_RESULT_DUE_OUT)) else $error("ident off mode not held in reset");
AST_BW_EXTRA: assert property (FILT_WIDTH_OUT == SDCR_FBW_EXTRA |-> CH1_BW_OUT == SDCR_BW_EXTRA_WIDE
    && CH2_BW_OUT == SDCR_BW_NARROW && !CH2_FM_ALLOWED_OUT) else $error("extra wide filter mode wrong");
AST_DECIM: assert property (CH2_WIDE_DECIM_OUT == (DEMOD_CONFIG_OUT[3:2] == SDCR_CH2_NICAM))
    else $error("channel two decimation width wrong");
endmodule

bind sdcr_regs sdcr_regs_checker i_sdcr_regs_checker (.*);

// ==== dv/sdcr_host_model.sv ====
// host model: serial bus master issuing subaddressed write transfers
`timescale 1ns/1ns
module sdcr_host_model
    import sdcr_pkg::*;
(
    input wire logic clk_in,
    output logic start_out,
    output logic [7:0] sub_out,
    output logic strobe_out,
    output logic [7:0] data_out,
    output logic end_out
);
initial begin
    start_out = 1'b0;
    sub_out = 8'h00;
    strobe_out = 1'b0;
    data_out = 8'h00;
    end_out = 1'b0;
end
// integer part of carrier_freq / mixer_clock_freq * 2^24
function automatic logic [23:0] freq_word(input longint khz);
    return 24'((khz << SDCR_WORD_STEPS_LOG2) / SDCR_MIXER_CLOCK_FREQ_KHZ);
endfunction
// direct register writes only, never the easy standard path; fewer bytes model an early stop
task automatic xfer(input logic [7:0] sub, input logic [7:0] bytes[$]);
    @(posedge clk_in);
    start_out <= 1'b1;
    sub_out <= sub;
    foreach (bytes[i]) begin
        @(posedge clk_in);
        start_out <= 1'b0;
        sub_out <= ~sub;
        strobe_out <= 1'b1;
        data_out <= bytes[i];
    end
    @(posedge clk_in);
    start_out <= 1'b0;
    sub_out <= ~sub;
    strobe_out <= 1'b0;
    data_out <= ~data_out;
    end_out <= 1'b1;
    @(posedge clk_in);
    end_out <= 1'b0;
    #1;
endtask
endmodule

// ==== dv/sdcr_regs_tb.sv ====
// self-checking bench for the configuration register bank
`timescale 1ns/1ns
module sdcr_regs_tb
    import sdcr_pkg::*;
;
logic clk = 1'b0;
logic rst_n = 1'b0;
logic start, strobe, xend;
logic [7:0] sub, data, mon, cfg;
logic [23:0] c1_word, c2_word, w1, w2;
logic c1_ld, c2_ld, c2_nicam, m_avg, m_one, m_two, id_rst, korea, due, ch1_fm, ch2_fm, ch1_am, wide;
logic [3:0] m_src;
logic [1:0] id_time, fw, ch2_mode;
sdcr_bw_type bw1, bw2;
int n_mismatch = 0;
int n_compared = 0;
int n_ld1 = 0;
int n_ld2 = 0;
sdcr_bw_type exp_bw1[4] = '{SDCR_BW_NARROW, SDCR_BW_EXTRA_WIDE, SDCR_BW_MEDIUM, SDCR_BW_WIDE};
sdcr_bw_type exp_bw2[4] = '{SDCR_BW_NARROW, SDCR_BW_NARROW, SDCR_BW_MEDIUM, SDCR_BW_WIDE};

always #2 clk = ~clk;
always @(negedge clk) begin
    n_ld1 += int'(c1_ld === 1'b1);
    n_ld2 += int'(c2_ld === 1'b1);
end

sdcr_host_model u_host (.clk_in(clk), .start_out(start), .sub_out(sub), .strobe_out(strobe),
    .data_out(data), .end_out(xend));
sdcr_regs #(.IDENT_SLOW_CYCLES(32'h00000008), .IDENT_MEDIUM_CYCLES(32'h00000004),
    .IDENT_FAST_CYCLES(32'h00000002)) i_sdcr_regs (
    .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .XFER_START_IN(start), .XFER_SUBADDR_IN(sub),
    .BYTE_STROBE_IN(strobe), .BYTE_DATA_IN(data), .XFER_END_IN(xend),
    .CARRIER_ONE_WORD_OUT(c1_word), .CARRIER_ONE_LOAD_OUT(c1_ld), .CARRIER_TWO_WORD_OUT(c2_word),
    .CARRIER_TWO_LOAD_OUT(c2_ld), .CARRIER_TWO_NICAM_OUT(c2_nicam), .MON_CHAN_AVG_OUT(m_avg),
    .MON_CHAN_ONE_OUT(m_one), .MON_CHAN_TWO_OUT(m_two), .MON_SRC_SEL_OUT(m_src), .MON_SELECT_OUT(mon),
    .DEMOD_CONFIG_OUT(cfg), .IDENT_TIME_OUT(id_time), .IDENT_RESET_OUT(id_rst),
    .IDENT_REGION_KOREA_OUT(korea), .IDENT_RESULT_DUE_OUT(due), .FILT_WIDTH_OUT(fw),
    .CH1_BW_OUT(bw1), .CH2_BW_OUT(bw2), .CH1_FM_ALLOWED_OUT(ch1_fm), .CH2_FM_ALLOWED_OUT(ch2_fm),
    .CHAN_ONE_AM_OUT(ch1_am), .CHAN_TWO_MODE_OUT(ch2_mode), .CH2_WIDE_DECIM_OUT(wide)
);

task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
        n_mismatch++;
        $display("Error %s expected %h seen %h", what, exp, got);
    end
endtask

task automatic summarize();
    if (n_mismatch == 0 && n_compared > 0) begin
        $display("All checks passed");
    end else begin
        $display("Checks failed");
    end
    $finish;
endtask

// due stays low until exactly twice the integrator time has passed since the config byte edge
task automatic ident_due(input logic [7:0] c, input int n);
    u_host.xfer(SDCR_SUB_DEMOD_CFG, {c});
    repeat (n - 2) @(posedge clk);
    #1;
    chk("ident due early", 24'h0, {23'h0, due});
    @(posedge clk);
    #1;
    chk("ident due late", 24'h1, {23'h0, due});
endtask

// ------------------------------------------------------------
// main sequence
// ------------------------------------------------------------
initial begin
    logic [1:0] ch;
    logic [7:0] b;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("c1 word reset", 24'h000000, c1_word);
    chk("config reset", {16'h0, SDCR_CFG_RESET}, {16'h0, cfg});
    chk("monitor average at reset", 24'h1, {23'h0, m_avg});
    w1 = u_host.freq_word(5500);
    w2 = u_host.freq_word(5850);
    // both carriers and the config byte in one auto-incrementing transfer
    u_host.xfer(SDCR_SUB_C1_HIGH, {w1[23:16], w1[15:8], w1[7:0], w2[23:16], w2[15:8], w2[7:0], 8'h08});
    chk("c1 word", 24'h729555, c1_word);
    chk("c1 commits", 24'h1, 24'(n_ld1));
    chk("c2 word", 24'h79E000, c2_word);
    chk("c2 nicam", 24'h3, {22'h0, c2_nicam, wide});
    u_host.xfer(SDCR_SUB_C2_HIGH, {8'h12, 8'h34});
    u_host.xfer(SDCR_SUB_C2_LOW, {8'h56});
    chk("c2 after partial", 24'h79E000, c2_word);
    chk("c2 commits", 24'h1, 24'(n_ld2));
    u_host.xfer(8'h01, {8'hFF, 8'hEF});
    chk("monitor after unmapped", 24'h0B, {16'h0, mon});
    for (int i = 0; i < 4; i++) begin
        ch = 2'(i % 3);
        b = {3'h7, ch, 1'b1, 2'(i)};
        u_host.xfer(SDCR_SUB_MON_SELECT, {b});
        chk("monitor byte", {16'h0, b & SDCR_MON_MASK}, {16'h0, mon});
        chk("monitor channel", 24'(3'h1 << ch), {21'h0, m_two, m_one, m_avg});
        chk("monitor source", 24'(4'h1 << i), {20'h0, m_src});
    end
    for (int i = 0; i < 4; i++) begin
        ch = 2'(i % 3);
        b = {2'(i), i[0], i[1], ch, i[0], i[0]};
        u_host.xfer(SDCR_SUB_DEMOD_CFG, {b});
        chk("config byte", {16'h0, b}, {16'h0, cfg});
        chk("config decode", {8'h0, 2'(i), i == 3, i[0], 2'(i), exp_bw1[i], exp_bw2[i], i != 1, i[0], !i[0], ch,
            ch == SDCR_CH2_NICAM}, {8'h0, id_time, id_rst, korea, fw, bw1, bw2, ch2_fm, ch1_am, ch1_fm,
            ch2_mode, wide});
    end
    repeat (20) @(posedge clk);
    #1;
    chk("ident off due", 24'h0, {23'h0, due});
    ident_due(8'h80, 4);
    ident_due(8'h40, 8);
    ident_due(8'h00, 16);
    summarize();
end
endmodule
